/* src/gcm_top.sv */
// Purpose: Gated 32-bit signed up/down pulse counter with endless, one-time and periodic modes
// Assumes: Encoder pulses and external gate arrive asynchronously on pins
// Notes:   Comparator, latch, reset input and hysteresis are not part of this block
//
// Functional notes
// - Counting starts only after a mode is configured and the gate opens.
// - Count is signed 32-bit; limits fixed by width.
// - Modes endless, one-time, periodic; latter two with optional primary direction.
// - One-time and periodic ranges with primary direction bounded by load and end values.
// - Preset bit rising edge copies set value into count.
// - Without primary direction the full signed range is used.
// - Primary up: count to end minus one, next pulse reloads load value.
// - Primary down: count to end plus one, next pulse reloads load value.
// - Internal gate is software gate, ANDed with external gate when enabled.
// - Software gate opens on open-bit edge, closes on close-bit edge.
// - On gate reopen, resume (interrupt) or restart from load (cancel).
// - Endless starts at load, wraps max to min and min to max.
// - Limit exceed sets sticky overflow/underflow until cleared and pulses optional alarm for one cycle.
// - One-time no direction: wrap to opposite limit, close gate, flag.
// - After that closure host reopens gate; resume per interrupt/cancel.
// - One-time up: pulse after end minus one reloads, closes gate, flags end.
// - One-time with direction: after end, reopen restarts at load value.
// - One-time down: pulse after end plus one reloads, closes gate, flags end.
// - Primary up: lower limit wraps to upper, continues, flags underflow.
// - Primary down: upper limit wraps to lower, continues, flags overflow.
// - Periodic no direction: a limit reloads load value, continues, flags.
// - Periodic up: pulse after end minus one reloads, gate stays open, flags end.
// - Status-clear bit edge clears all sticky status bits.
`timescale 1ns/1ps
module gcm_top
  import gcm_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   cnt_up_pin,
  input  wire logic                   cnt_down_pin,
  input  wire logic                   ext_gate_pin,
  input  wire logic [GCM_ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  output logic                        alarm_q,
  output logic                        gate_open_q
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0]   up_sync_q;
  logic [2:0]   dn_sync_q;
  logic [1:0]   gate_sync_q;

  // Third stage only feeds edge detection, never the first stage
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      up_sync_q   <= 3'h0;
      dn_sync_q   <= 3'h0;
      gate_sync_q <= 2'h0;
    end
    else
    begin
      up_sync_q   <= {up_sync_q[1:0], cnt_up_pin};
      dn_sync_q   <= {dn_sync_q[1:0], cnt_down_pin};
      gate_sync_q <= {gate_sync_q[0], ext_gate_pin};
    end
  end

  logic step_up;
  logic step_dn;

  // Simultaneous up and down cancel each other
  assign step_up = up_sync_q[1] & ~up_sync_q[2] & ~(dn_sync_q[1] & ~dn_sync_q[2]);
  assign step_dn = dn_sync_q[1] & ~dn_sync_q[2] & ~(up_sync_q[1] & ~up_sync_q[2]);

  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic [GCM_CTRL_W-1:0]  ctrl_q;
  logic signed [31:0]     setval_q;
  logic signed [31:0]     load_q;
  logic signed [31:0]     end_q;
  gcm_cfg_t               cfg_q;
  logic                   cfg_valid_q;
  logic                   wr_ctrl;

  assign wr_ctrl = reg_wr && (reg_addr == GCM_OFS_CTRL);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrl_q      <= GCM_RST_CTRL;
      setval_q    <= GCM_RST_WORD;
      load_q      <= GCM_RST_WORD;
      end_q       <= GCM_RST_WORD;
      cfg_q       <= '0;
      cfg_valid_q <= 1'b0;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        GCM_OFS_CTRL:   ctrl_q   <= reg_wdata[GCM_CTRL_W-1:0];
        GCM_OFS_SETVAL: setval_q <= reg_wdata;
        GCM_OFS_LOAD:   load_q   <= reg_wdata;
        GCM_OFS_END:    end_q    <= reg_wdata;
        GCM_OFS_CFG:
        begin
          cfg_q       <= reg_wdata[$bits(gcm_cfg_t)-1:0];
          cfg_valid_q <= 1'b1;
        end
        default:        ;
      endcase
    end
  end

  // Control bits act on a 0-1 transition of the written word
  logic [GCM_CTRL_W-1:0] ctrl_rise;
  logic                  open_edge;
  logic                  close_edge;
  logic                  preset_edge;
  logic                  clear_edge;

  assign ctrl_rise   = wr_ctrl ? (reg_wdata[GCM_CTRL_W-1:0] & ~ctrl_q) : '0;
  assign open_edge   = ctrl_rise[GCM_BIT_GATE_OPEN] & cfg_valid_q;
  assign close_edge  = ctrl_rise[GCM_BIT_GATE_CLOSE];
  assign preset_edge = ctrl_rise[GCM_BIT_PRESET_LOAD];
  assign clear_edge  = ctrl_rise[GCM_BIT_STAT_CLEAR];

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  gcm_mode_t mode;
  gcm_dir_t  pdir;

  always_comb
  begin
    mode = gcm_mode_t'(cfg_q.mode);
    pdir = gcm_dir_t'(cfg_q.dir);
    unique case (mode)
      GCM_ENDLESS:  pdir = GCM_DIR_NONE;
      GCM_ONCE,
      GCM_PERIODIC: ;
      default:
      begin
        // Unused mode code behaves as endless
        mode = GCM_ENDLESS;
        pdir = GCM_DIR_NONE;
      end
    endcase
    if (pdir != GCM_DIR_UP && pdir != GCM_DIR_DOWN)
    begin
      pdir = GCM_DIR_NONE;
    end
  end

  // ****************************************************************
  // Gate
  // ****************************************************************
  logic software_enable_gate_q;
  logic gate_prev_q;
  logic started_q;
  logic int_gate;
  logic gate_rise;
  logic auto_close;

  assign int_gate  = software_enable_gate_q & (gate_sync_q[1] | ~cfg_q.external_enable_gate_en);
  assign gate_rise = int_gate & ~gate_prev_q;

  // Reopen by host wins over an automatic close in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      software_enable_gate_q <= 1'b0;
    end
    else if (open_edge)
    begin
      software_enable_gate_q <= 1'b1;
    end
    else if (close_edge || auto_close)
    begin
      software_enable_gate_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      gate_prev_q <= 1'b0;
      started_q   <= 1'b0;
      gate_open_q <= 1'b0;
    end
    else
    begin
      gate_prev_q <= int_gate;
      gate_open_q <= int_gate;
      if (gate_rise)
      begin
        started_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Counter
  // ****************************************************************
  logic signed [31:0] cnt_q;
  logic signed [31:0] cnt_d;
  logic signed [31:0] end_m1;
  logic signed [31:0] end_p1;
  logic               ev_ovf;
  logic               ev_unf;
  logic               ev_end;
  logic               dir_up_q;
  logic               dir_dn_q;

  assign end_m1 = end_q - 32'sh1;
  assign end_p1 = end_q + 32'sh1;

  always_comb
  begin
    cnt_d      = cnt_q;
    ev_ovf     = 1'b0;
    ev_unf     = 1'b0;
    ev_end     = 1'b0;
    auto_close = 1'b0;
    if (preset_edge)
    begin
      cnt_d = setval_q;
    end
    else if (gate_rise)
    begin
      // First start always begins at the load value
      if (cfg_q.cancel || !started_q)
      begin
        cnt_d = load_q;
      end
    end
    else if (int_gate && step_up)
    begin
      if (pdir == GCM_DIR_UP && cnt_q == end_m1)
      begin
        cnt_d      = load_q;
        ev_end     = 1'b1;
        auto_close = (mode == GCM_ONCE);
      end
      else if (cnt_q == GCM_CNT_MAX)
      begin
        ev_ovf = 1'b1;
        if (mode == GCM_PERIODIC && pdir == GCM_DIR_NONE)
        begin
          cnt_d = load_q;
        end
        else
        begin
          cnt_d = GCM_CNT_MIN;
        end
        auto_close = (mode == GCM_ONCE && pdir == GCM_DIR_NONE);
      end
      else
      begin
        cnt_d = cnt_q + 32'sh1;
      end
    end
    else if (int_gate && step_dn)
    begin
      if (pdir == GCM_DIR_DOWN && cnt_q == end_p1)
      begin
        cnt_d      = load_q;
        ev_end     = 1'b1;
        auto_close = (mode == GCM_ONCE);
      end
      else if (cnt_q == GCM_CNT_MIN)
      begin
        ev_unf = 1'b1;
        if (mode == GCM_PERIODIC && pdir == GCM_DIR_NONE)
        begin
          cnt_d = load_q;
        end
        else
        begin
          cnt_d = GCM_CNT_MAX;
        end
        auto_close = (mode == GCM_ONCE && pdir == GCM_DIR_NONE);
      end
      else
      begin
        cnt_d = cnt_q - 32'sh1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_q <= GCM_RST_WORD;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  // Last counted direction, for status readback
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      dir_up_q <= 1'b0;
      dir_dn_q <= 1'b0;
    end
    else if (int_gate && (step_up || step_dn))
    begin
      dir_up_q <= step_up;
      dir_dn_q <= step_dn;
    end
  end

  // ****************************************************************
  // Sticky status and alarm
  // ****************************************************************
  gcm_sticky_t sticky_q;
  gcm_sticky_t sticky_set;

  // Comparator and zero crossing are not built, so those flags stay low
  always_comb
  begin
    sticky_set             = '0;
    sticky_set.overflow    = ev_ovf;
    sticky_set.underflow   = ev_unf;
    sticky_set.end_reached = ev_end;
  end

  // An event in the clearing cycle survives
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sticky_q <= '0;
    end
    else
    begin
      sticky_q <= (clear_edge ? '0 : sticky_q) | sticky_set;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      alarm_q <= 1'b0;
    end
    else
    begin
      alarm_q <= cfg_q.alarm_en & (ev_ovf | ev_unf | ev_end);
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  logic [31:0] status_word;

  assign status_word = {21'h0, cfg_valid_q, sticky_q, dir_up_q, dir_dn_q,
                        int_gate, gate_sync_q[1], software_enable_gate_q};

  // Unmapped addresses read zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      reg_rdata <= GCM_RST_WORD;
    end
    else if (reg_rd)
    begin
      unique case (reg_addr)
        GCM_OFS_CTRL:   reg_rdata <= {16'h0, ctrl_q};
        GCM_OFS_SETVAL: reg_rdata <= setval_q;
        GCM_OFS_LOAD:   reg_rdata <= load_q;
        GCM_OFS_END:    reg_rdata <= end_q;
        GCM_OFS_CFG:    reg_rdata <= {25'h0, cfg_q};
        GCM_OFS_STATUS: reg_rdata <= status_word;
        GCM_OFS_COUNT:  reg_rdata <= cnt_q;
        default:        reg_rdata <= GCM_RST_WORD;
      endcase
    end
    else
    begin
      reg_rdata <= GCM_RST_WORD;
    end
  end

endmodule : gcm_top

/* src/gcm_pkg.sv */
// Purpose: Shared constants and types for the gated up/down pulse counter
// Assumes: One clock (clk_sys, 50 MHz), synchronous active-high reset
// Notes:   Register offsets are byte addresses of 32-bit words
package gcm_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned GCM_ADDR_W      = 8;
  localparam logic [7:0]  GCM_OFS_CTRL    = 8'h00;
  localparam logic [7:0]  GCM_OFS_SETVAL  = 8'h04;
  localparam logic [7:0]  GCM_OFS_LOAD    = 8'h08;
  localparam logic [7:0]  GCM_OFS_END     = 8'h0C;
  localparam logic [7:0]  GCM_OFS_CFG     = 8'h10;
  localparam logic [7:0]  GCM_OFS_STATUS  = 8'h14;
  localparam logic [7:0]  GCM_OFS_COUNT   = 8'h18;

  // ****************************************************************
  // Control word bit positions
  // ****************************************************************
  localparam int unsigned GCM_CTRL_W          = 16;
  localparam int unsigned GCM_BIT_GATE_OPEN   = 2;
  localparam int unsigned GCM_BIT_PRESET_LOAD = 5;
  localparam int unsigned GCM_BIT_STAT_CLEAR  = 6;
  localparam int unsigned GCM_BIT_GATE_CLOSE  = 10;

  // ****************************************************************
  // Count limits and reset values
  // ****************************************************************
  localparam logic signed [31:0] GCM_CNT_MAX   = 32'sh7FFFFFFF;
  localparam logic signed [31:0] GCM_CNT_MIN   = 32'sh80000000;
  localparam logic [31:0]        GCM_RST_WORD  = 32'h00000000;
  localparam logic [15:0]        GCM_RST_CTRL  = 16'h0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {GCM_ENDLESS, GCM_ONCE, GCM_PERIODIC} gcm_mode_t;
  typedef enum logic [1:0] {GCM_DIR_NONE, GCM_DIR_UP, GCM_DIR_DOWN} gcm_dir_t;

  // Configuration word, high bits first
  typedef struct packed {
    logic      alarm_en;
    logic      cancel;
    logic      external_enable_gate_en;
    logic [1:0] dir;
    logic [1:0] mode;
  } gcm_cfg_t;

  // Sticky status flags
  typedef struct packed {
    logic zero_cross;
    logic underflow;
    logic overflow;
    logic end_reached;
    logic cmp_met;
  } gcm_sticky_t;

endpackage : gcm_pkg

/* verif/gcm_enc_model.sv */
// Purpose: Encoder stand-in driving the count pins
// Assumes: Step requests are one-cycle strobes
// Notes:   Pins rest low between pulses
`timescale 1ns/1ps
module gcm_enc_model (
  input  wire logic clk_sys,
  input  wire logic step_up,
  input  wire logic step_dn,
  output logic      cnt_up_pin,
  output logic      cnt_down_pin,
  output logic      busy
);
  // ***************
  // Pulse shaper
  // ***************
  logic [2:0] tick_q = 3'h0;
  logic       dn_q   = 1'b0;
  // Three high, three low: above the two-clock minimum
  assign busy         = tick_q != 3'h0;
  assign cnt_up_pin   = tick_q > 3'h3 && !dn_q;
  assign cnt_down_pin = tick_q > 3'h3 && dn_q;
  always @(posedge clk_sys)
  begin
    if (tick_q != 3'h0)
      tick_q <= tick_q - 3'h1;
    else if (step_up || step_dn)
    begin
      tick_q <= 3'h6;
      dn_q   <= step_dn;
    end
  end
endmodule : gcm_enc_model

/* verif/gcm_properties.sv */
// Purpose: Port-level checks for the gated counter
// Assumes: Shadows of CTRL and CFG follow host writes
// Notes:   Delays allow for the two-flop input sync
`timescale 1ns/1ps
module gcm_properties
  import gcm_pkg::*;
(
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  cnt_up_pin,
  input wire logic                  cnt_down_pin,
  input wire logic                  ext_gate_pin,
  input wire logic [GCM_ADDR_W-1:0] reg_addr,
  input wire logic [31:0]           reg_wdata,
  input wire logic                  reg_wr,
  input wire logic                  reg_rd,
  input wire logic [31:0]           reg_rdata,
  input wire logic                  alarm_q,
  input wire logic                  gate_open_q
);
  // ***************
  // Host shadows
  // ***************
  logic [31:0] ctrl_q;
  logic [6:0]  cfg_q;
  logic        cfg_ok_q;
  logic        wr_ctrl;
  logic        open_edge;
  logic        close_edge;
  assign wr_ctrl    = reg_wr && reg_addr == GCM_OFS_CTRL;
  assign open_edge  = wr_ctrl && reg_wdata[GCM_BIT_GATE_OPEN] && !ctrl_q[GCM_BIT_GATE_OPEN];
  assign close_edge = wr_ctrl && reg_wdata[GCM_BIT_GATE_CLOSE] && !ctrl_q[GCM_BIT_GATE_CLOSE];
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrl_q   <= 32'h0;
      cfg_q    <= 7'h0;
      cfg_ok_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= reg_wdata;
      if (reg_wr && reg_addr == GCM_OFS_CFG)
      begin
        cfg_q    <= reg_wdata[6:0];
        cfg_ok_q <= 1'b1;
      end
    end
  end
  // ***************
  // Assertions
  // ***************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  reset_idle_a: assert property ($fell(rst) |-> !gate_open_q && !alarm_q && reg_rdata == 32'h0)
    else $error("outputs busy after reset");
  no_cfg_gate_a: assert property (!cfg_ok_q |-> !gate_open_q)
    else $error("gate open before configuration");
  gate_opens_a: assert property (open_edge && cfg_ok_q && !cfg_q[4] |-> ##[1:3] gate_open_q)
    else $error("gate did not open");
  gate_closes_a: assert property (close_edge && !open_edge |-> ##[1:3] !gate_open_q)
    else $error("gate did not close");
  external_enable_gate_and_a: assert property ((cfg_q[4] && !ext_gate_pin)[*5] |-> !gate_open_q)
    else $error("gate open with external gate low");
  closed_quiet_a: assert property ((!gate_open_q)[*3] |=> !alarm_q)
    else $error("alarm while gate closed");
  alarm_off_a: assert property ((!cfg_q[6])[*3] |-> !alarm_q)
    else $error("alarm while disabled");
  alarm_pulse_a: assert property (alarm_q |=> !alarm_q)
    else $error("alarm longer than one cycle");
  alarm_cause_a: assert property (alarm_q |-> $past(cnt_up_pin, 3) || $past(cnt_down_pin, 3))
    else $error("alarm without a count pulse");
endmodule : gcm_properties

bind gcm_top gcm_properties i_props (.clk_sys(clk_sys), .rst(rst), .cnt_up_pin(cnt_up_pin),
  .cnt_down_pin(cnt_down_pin), .ext_gate_pin(ext_gate_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alarm_q(alarm_q), .gate_open_q(gate_open_q));

/* verif/gcm_top_bench.sv */
// Purpose: Self-checking bench for the gated counter
// Assumes: Reads checked one cycle after the strobe
// Notes:   Wrap cases come from a row table
`timescale 1ns/1ps
module gcm_top_bench;
  import gcm_pkg::*;
  logic        clk_sys      = 1'b0;
  logic        rst          = 1'b1;
  logic        ext_gate_pin = 1'b0;
  logic [7:0]  reg_addr     = 8'h00;
  logic [31:0] reg_wdata    = 32'h0;
  logic        reg_wr       = 1'b0;
  logic        reg_rd       = 1'b0;
  logic        step_up      = 1'b0;
  logic        step_dn      = 1'b0;
  logic        rd_seen      = 1'b0;
  logic        cnt_up_pin;
  logic        cnt_down_pin;
  logic        busy;
  logic        alarm_q;
  logic        gate_open_q;
  logic [31:0] reg_rdata;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          bad_count    = 0;
  int          checked      = 0;
  int          seed         = 32'h891b6127;
  // Row: cfg, preset pick, down, result pick, reopen, status
  logic [31:0] rows [9] = '{32'h40080084, 32'h40600104, 32'h42700104, 32'h46600104, 32'h4A080084,
                            32'h610C0080, 32'h45940040, 32'h49F40040, 32'h46900044};
  always #10 clk_sys = ~clk_sys;
  gcm_top i_dut (.clk_sys(clk_sys), .rst(rst), .cnt_up_pin(cnt_up_pin), .cnt_down_pin(cnt_down_pin),
    .ext_gate_pin(ext_gate_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alarm_q(alarm_q), .gate_open_q(gate_open_q));
  gcm_enc_model i_enc (.clk_sys(clk_sys), .step_up(step_up), .step_dn(step_dn),
    .cnt_up_pin(cnt_up_pin), .cnt_down_pin(cnt_down_pin), .busy(busy));
  // ***************
  // Tasks
  // ***************
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    checked++;
    if ((got & msk) !== (exp & msk))
    begin
      bad_count++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_flag
  // Gap edge after each strobe so no strobe is driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(posedge clk_sys);
  endtask : rd
  task automatic step(input logic dn, output logic al);
    al = 1'b0;
    step_up <= !dn;
    step_dn <= dn;
    @(posedge clk_sys);
    step_up <= 1'b0;
    step_dn <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      al = al | alarm_q;
    end
  endtask : step
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  always @(posedge clk_sys)
  begin
    if (rd_seen && exp_q.size() > 0)
      cmp_word(reg_rdata, exp_q.pop_front(), msk_q.pop_front());
    rd_seen <= reg_rd;
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    $display("[ERR] %0t run did not finish in time", $time);
    print_verdict();
  end
  // ***************
  // Main sequence
  // ***************
  initial
  begin
    logic        al;
    logic [31:0] e;
    logic [31:0] load_v;
    logic [31:0] endv;
    logic [31:0] r;
    logic [31:0] vals [3];
    int          n;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(8'h1C, 32'h0, ~32'h0);
    wr(GCM_OFS_CTRL, 32'h4);
    step(1'b0, al);
    rd(GCM_OFS_STATUS, 32'h0, 32'h404);
    rd(GCM_OFS_COUNT, 32'h0, ~32'h0);
    load_v = {2'h0, 30'($random(seed))};
    wr(GCM_OFS_LOAD, load_v);
    wr(GCM_OFS_CFG, 32'h0);
    wr(GCM_OFS_CTRL, 32'h0);
    wr(GCM_OFS_CTRL, 32'h4);
    rd(GCM_OFS_COUNT, load_v, ~32'h0);
    e = load_v + 32'h1;
    n = 2 + ($random(seed) & 3);
    repeat (n) step(1'b0, al);
    step(1'b1, al);
    cmp_flag(al, 1'b0);
    e = e + n - 2;
    rd(GCM_OFS_COUNT, e, ~32'h0);
    wr(GCM_OFS_CTRL, 32'h404);
    step(1'b0, al);
    wr(GCM_OFS_CTRL, 32'h0);
    wr(GCM_OFS_CTRL, 32'h4);
    rd(GCM_OFS_COUNT, e, ~32'h0);
    wr(GCM_OFS_CFG, 32'h10);
    step(1'b0, al);
    rd(GCM_OFS_COUNT, e, ~32'h0);
    ext_gate_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    step(1'b0, al);
    rd(GCM_OFS_COUNT, e + 32'h1, ~32'h0);
    cmp_flag(gate_open_q, 1'b1);
    foreach (rows[i])
    begin
      r = rows[i];
      endv = (r[27:26] == 2'h2) ? load_v - 32'h5 : load_v + 32'h5;
      vals = '{GCM_CNT_MAX, GCM_CNT_MIN, load_v};
      e = r[23] ? endv + (r[22] ? 32'h1 : 32'hFFFFFFFF) : vals[r[22]];
      wr(GCM_OFS_END, endv);
      wr(GCM_OFS_CFG, {24'h0, r[31:24]});
      wr(GCM_OFS_SETVAL, e);
      wr(GCM_OFS_CTRL, 32'h0);
      wr(GCM_OFS_CTRL, 32'h44);
      wr(GCM_OFS_CTRL, 32'h24);
      rd(GCM_OFS_STATUS, 32'h0, 32'h1C0);
      rd(GCM_OFS_COUNT, e, ~32'h0);
      step(r[21], al);
      cmp_flag(al, 1'b1);
      rd(GCM_OFS_COUNT, vals[r[20:19]], ~32'h0);
      rd(GCM_OFS_STATUS, {22'h0, r[9:0]}, 32'h1C4);
      if (r[18])
      begin
        wr(GCM_OFS_CTRL, 32'h0);
        wr(GCM_OFS_CTRL, 32'h4);
        rd(GCM_OFS_COUNT, load_v, ~32'h0);
      end
    end
    repeat (2) @(posedge clk_sys);
    print_verdict();
  end
endmodule : gcm_top_bench
